/* src/pin_alt_pkg.sv */
package pin_alt_pkg;

  // timing of the two-wire spike filter
  localparam int SYS_CLK_MHZ = 200;
  localparam int SPIKE_NS = 50;
  // least time, so round up to whole cycles
  localparam int SPIKE_CYC = (SPIKE_NS * SYS_CLK_MHZ + 999) / 1000;

  // port D pin positions
  localparam int PD_SCL = 0;
  localparam int PD_SDA = 1;
  localparam int PD_RXD = 2;
  localparam int PD_TXD = 3;
  localparam int PD_CAP = 4;
  localparam int PD_XCK = 5;
  localparam int PD_T1 = 6;
  localparam int PD_T2 = 7;

  // port E pin positions
  localparam int PE_RXD = 0;
  localparam int PE_TXD = 1;
  localparam int PE_XCK = 2;
  localparam int PE_OCA = 3;
  localparam int PE_OCB = 4;
  localparam int PE_OCC = 5;
  localparam int PE_T3 = 6;
  localparam int PE_CAP = 7;

  // reset values
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic FILT_RST = 1'b1;

endpackage

/* src/spike_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spike_if #(parameter int W = 2);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt(input raw, output clean);
  modport user(output raw, input clean);
endinterface
`default_nettype wire

/* src/spike_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module spike_filter import pin_alt_pkg::*; #(
  parameter int W = 2,
  parameter int CYC = SPIKE_CYC
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rstn,    // synchronous reset, active low
  spike_if.filt lines         // synchronised lines in, filtered lines out
);
  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [W-1:0] out;
    logic [W-1:0][CW-1:0] cnt;
  } filt_state_s;

  filt_state_s st_ff;
  filt_state_s nxt_st;

  // a new level is taken only after it has stood for CYC cycles in a row
  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < W; i++) begin
      if (lines.raw[i] == st_ff.out[i]) begin
        nxt_st.cnt[i] = '0;
      end else if (st_ff.cnt[i] == CW'(CYC - 1)) begin
        nxt_st.out[i] = lines.raw[i]; // R06
        nxt_st.cnt[i] = '0;
      end else begin
        nxt_st.cnt[i] = st_ff.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_ff.out <= {W{FILT_RST}};
      st_ff.cnt <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lines.clean = st_ff.out;

  // helper: how long each raw line has stood still, saturating
  logic [W-1:0][5:0] run_ff;
  logic [W-1:0] raw_d_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      run_ff <= '0;
      raw_d_ff <= '0;
    end else begin
      raw_d_ff <= lines.raw;
      for (int i = 0; i < W; i++) begin
        if (lines.raw[i] != raw_d_ff[i]) begin
          run_ff[i] <= 6'h01;
        end else if (run_ff[i] != 6'h3F) begin
          run_ff[i] <= run_ff[i] + 6'h01;
        end
      end
    end
  end

  // the run counter steps on the same edge as the filtered output it justifies, so compare its present value
  localparam int SPIKE_MIN = CYC;
  for (genvar g = 0; g < W; g++) begin : g_chk
    AST_SPIKE_REJECT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R06
      $changed(st_ff.out[g]) |-> (run_ff[g] >= SPIKE_MIN))
      else $error("filtered line changed after a pulse shorter than the spike limit");
  end
endmodule
`default_nettype wire

/* src/pin_alt_override.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// (R01) each attribute takes the override value when its enable is set, else port registers
// (R02) usart1 receiver forces D2 to input; pin feeds the receive line
// (R03) D2 pull-up follows port bit, gated by global pull-up disable, while receiving
// (R04) two-wire enable detaches D1; it becomes the SDA line
// (R05) two-wire enable detaches D0; it becomes the SCL line
// (R06) SDA and SCL inputs filtered; pulses under 50 ns discarded
// (R07) two-wire pins open drain: value zero, drive-low sets direction, gated pull-up
// (R08) usart1 transmitter forces D3 output with transmit data, pull-up off
// (R09) external interrupt enable forces digital input enable on D0-D3, E4-E7
// (R10) usart1 sync mode drives D5 with clock out; D4, D6, D7 feed timers
// (R11) usart0 receiver forces E0 input; pull-up from port bit unless disabled
// (R12) usart0 transmitter forces E1 output with transmit data, pull-up off
// (R13) timer3 compare A/B/C replace E3-E5 values; software sets direction
// (R14) usart0 sync mode drives E2 value; direction bit picks clock in or out
// (R15) E7 feeds timer3 capture, E6 timer3 count, with no overrides
// (R16) serial programming uses E1 as data out and E0 as data in
module pin_alt_override import pin_alt_pkg::*; (
  input wire logic i_sys_clk,                // system clock, 200 MHz
  input wire logic i_rstn,                   // synchronous reset, active low
  input wire logic [7:0] i_portd_out,        // port D output register
  input wire logic [7:0] i_portd_dir,        // port D direction register, 1 = output
  input wire logic [7:0] i_portd_pin,        // port D pad levels, asynchronous
  input wire logic [7:0] i_porte_out,        // port E output register
  input wire logic [7:0] i_porte_dir,        // port E direction register, 1 = output
  input wire logic [7:0] i_porte_pin,        // port E pad levels, asynchronous
  input wire logic i_global_pullup_disable,  // 1 turns off all pull-ups
  input wire logic i_input_disable,          // 1 turns off digital inputs (sleep)
  input wire logic i_usart1_rx_enable,       // usart1 receiver on
  input wire logic i_usart1_tx_enable,       // usart1 transmitter on
  input wire logic i_usart1_tx_line,         // usart1 transmit data
  input wire logic i_usart1_sync_select,     // usart1 synchronous mode
  input wire logic i_usart1_ext_clock,       // usart1 clock output value
  input wire logic i_usart0_rx_enable,       // usart0 receiver on
  input wire logic i_usart0_tx_enable,       // usart0 transmitter on
  input wire logic i_usart0_tx_line,         // usart0 transmit data
  input wire logic i_usart0_sync_select,     // usart0 synchronous mode
  input wire logic i_usart0_ext_clock,       // usart0 clock output value
  input wire logic i_two_wire_enable,        // two-wire interface on
  input wire logic i_sda_drive_low,          // two-wire pulls SDA low
  input wire logic i_scl_drive_low,          // two-wire pulls SCL low
  input wire logic [7:0] i_ext_irq_enable,   // external interrupt 0..7 enables
  input wire logic [2:0] i_timer3_compare_en, // compare A/B/C output enables
  input wire logic [2:0] i_timer3_compare_out, // compare A/B/C output values
  input wire logic i_prog_serial_mode,       // serial program download active
  input wire logic i_prog_serial_data_out,   // programming data to send
  output logic [7:0] o_portd_pullup,         // port D pull-up on
  output logic [7:0] o_portd_oe,             // port D output enable
  output logic [7:0] o_portd_drive,          // port D output value
  output logic [7:0] o_portd_in_en,          // port D digital input enable
  output logic [7:0] o_portd_in,             // port D synchronised input data
  output logic [7:0] o_porte_pullup,         // port E pull-up on
  output logic [7:0] o_porte_oe,             // port E output enable
  output logic [7:0] o_porte_drive,          // port E output value
  output logic [7:0] o_porte_in_en,          // port E digital input enable
  output logic [7:0] o_porte_in,             // port E synchronised input data
  output logic o_usart1_rx_line,             // usart1 receive data
  output logic o_usart1_ext_clock_in,        // usart1 clock input
  output logic o_timer1_capture_in,          // timer1 capture trigger
  output logic o_timer1_count_in,            // timer1 count source
  output logic o_timer2_count_in,            // timer2 count source
  output logic o_sda_in,                     // filtered SDA to two-wire logic
  output logic o_scl_in,                     // filtered SCL to two-wire logic
  output logic [7:0] o_ext_irq_line,         // external interrupt 0..7 inputs
  output logic o_usart0_rx_line,             // usart0 receive data
  output logic o_usart0_ext_clock_in,        // usart0 clock input
  output logic o_timer3_capture_in,          // timer3 capture trigger
  output logic o_timer3_count_in,            // timer3 count source
  output logic o_prog_serial_data_in         // programming data received
);

  typedef struct packed {
    logic [7:0] d_s1, d_s2, e_s1, e_s2;
    logic [7:0] d_pu, d_oe, d_val, d_ie, d_in;
    logic [7:0] e_pu, e_oe, e_val, e_ie, e_in;
  } pin_state_s;

  pin_state_s st_ff;
  pin_state_s nxt_st;

  function automatic logic [7:0] pick(input logic [7:0] oe, input logic [7:0] ov, input logic [7:0] base);
    pick = (oe & ov) | (~oe & base); // R01
  endfunction

  logic [7:0] d_pullup_override_enable, d_pullup_override_value, d_direction_override_enable, d_direction_override_value, d_port_value_override_enable, d_port_value_override_value, d_input_enable_override_enable;
  logic [7:0] e_pullup_override_enable, e_pullup_override_value, e_direction_override_enable, e_direction_override_value, e_port_value_override_enable, e_port_value_override_value, e_input_enable_override_enable;
  logic [7:0] pu_gate, ie_base;
  logic tw, global_pullup_disable, prog;

  always_comb begin
    tw = i_two_wire_enable;
    global_pullup_disable = i_global_pullup_disable;
    prog = i_prog_serial_mode;
    pu_gate = {8{~global_pullup_disable}};
    ie_base = {8{~i_input_disable}};
    d_pullup_override_enable = PORT_RST;
    d_pullup_override_value = PORT_RST;
    d_direction_override_enable = PORT_RST;
    d_direction_override_value = PORT_RST;
    d_port_value_override_enable = PORT_RST;
    d_port_value_override_value = PORT_RST;
    e_pullup_override_enable = PORT_RST;
    e_pullup_override_value = PORT_RST;
    e_direction_override_enable = PORT_RST;
    e_direction_override_value = PORT_RST;
    e_port_value_override_enable = PORT_RST;
    e_port_value_override_value = PORT_RST;
    nxt_st = st_ff;

    // open-drain two-wire pins: value held zero, drive-low steers direction
    d_pullup_override_enable[PD_SDA] = tw; // R04
    d_pullup_override_value[PD_SDA] = i_portd_out[PD_SDA] & ~global_pullup_disable; // R07
    d_direction_override_enable[PD_SDA] = tw;
    d_direction_override_value[PD_SDA] = i_sda_drive_low; // R07
    d_port_value_override_enable[PD_SDA] = tw; // R07
    d_pullup_override_enable[PD_SCL] = tw; // R05
    d_pullup_override_value[PD_SCL] = i_portd_out[PD_SCL] & ~global_pullup_disable; // R07
    d_direction_override_enable[PD_SCL] = tw;
    d_direction_override_value[PD_SCL] = i_scl_drive_low; // R07
    d_port_value_override_enable[PD_SCL] = tw; // R07

    d_pullup_override_enable[PD_RXD] = i_usart1_rx_enable; // R03
    d_pullup_override_value[PD_RXD] = i_portd_out[PD_RXD] & ~global_pullup_disable; // R03
    d_direction_override_enable[PD_RXD] = i_usart1_rx_enable; // R02

    d_pullup_override_enable[PD_TXD] = i_usart1_tx_enable; // R08
    d_direction_override_enable[PD_TXD] = i_usart1_tx_enable; // R08
    d_direction_override_value[PD_TXD] = 1'b1;
    d_port_value_override_enable[PD_TXD] = i_usart1_tx_enable; // R08
    d_port_value_override_value[PD_TXD] = i_usart1_tx_line;

    d_port_value_override_enable[PD_XCK] = i_usart1_sync_select; // R10
    d_port_value_override_value[PD_XCK] = i_usart1_ext_clock;
    d_input_enable_override_enable = {4'h0, i_ext_irq_enable[3:0]}; // R09

    // programming mode takes E0/E1 ahead of usart0
    e_pullup_override_enable[PE_RXD] = i_usart0_rx_enable & ~prog; // R11
    e_pullup_override_value[PE_RXD] = i_porte_out[PE_RXD] & ~global_pullup_disable; // R11
    e_direction_override_enable[PE_RXD] = i_usart0_rx_enable | prog; // R11 R16
    e_pullup_override_enable[PE_TXD] = i_usart0_tx_enable | prog; // R12
    e_direction_override_enable[PE_TXD] = i_usart0_tx_enable | prog; // R12 R16
    e_direction_override_value[PE_TXD] = 1'b1;
    e_port_value_override_enable[PE_TXD] = i_usart0_tx_enable | prog; // R12
    e_port_value_override_value[PE_TXD] = prog ? i_prog_serial_data_out : i_usart0_tx_line; // R16
    e_port_value_override_enable[PE_XCK] = i_usart0_sync_select; // R14
    e_port_value_override_value[PE_XCK] = i_usart0_ext_clock;
    e_port_value_override_enable[PE_OCC:PE_OCA] = i_timer3_compare_en; // R13
    e_port_value_override_value[PE_OCC:PE_OCA] = i_timer3_compare_out; // R13
    e_input_enable_override_enable = {i_ext_irq_enable[7:4], 4'h0}; // R09

    nxt_st.d_s1 = i_portd_pin;
    nxt_st.d_s2 = st_ff.d_s1;
    nxt_st.e_s1 = i_porte_pin;
    nxt_st.e_s2 = st_ff.e_s1;
    nxt_st.d_pu = pick(d_pullup_override_enable, d_pullup_override_value, i_portd_out & ~i_portd_dir & pu_gate);
    nxt_st.d_oe = pick(d_direction_override_enable, d_direction_override_value, i_portd_dir);
    nxt_st.d_val = pick(d_port_value_override_enable, d_port_value_override_value, i_portd_out);
    nxt_st.d_ie = pick(d_input_enable_override_enable, 8'hFF, ie_base);
    nxt_st.e_pu = pick(e_pullup_override_enable, e_pullup_override_value, i_porte_out & ~i_porte_dir & pu_gate);
    nxt_st.e_oe = pick(e_direction_override_enable, e_direction_override_value, i_porte_dir);
    nxt_st.e_val = pick(e_port_value_override_enable, e_port_value_override_value, i_porte_out);
    nxt_st.e_ie = pick(e_input_enable_override_enable, 8'hFF, ie_base);
    nxt_st.d_in = st_ff.d_s2 & st_ff.d_ie;
    nxt_st.e_in = st_ff.e_s2 & st_ff.e_ie;
  end

  // reset leaves every pin an input with no pull-up
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // spike filter sees only the second synchroniser stage
  spike_if #(.W(2)) tw_lines();
  assign tw_lines.raw = {st_ff.d_s2[PD_SDA], st_ff.d_s2[PD_SCL]};
  spike_filter #(.W(2), .CYC(SPIKE_CYC)) u_spike (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .lines(tw_lines.filt)
  );

  assign o_portd_pullup = st_ff.d_pu;
  assign o_portd_oe = st_ff.d_oe;
  assign o_portd_drive = st_ff.d_val;
  assign o_portd_in_en = st_ff.d_ie;
  assign o_portd_in = st_ff.d_in;
  assign o_porte_pullup = st_ff.e_pu;
  assign o_porte_oe = st_ff.e_oe;
  assign o_porte_drive = st_ff.e_val;
  assign o_porte_in_en = st_ff.e_ie;
  assign o_porte_in = st_ff.e_in;
  assign o_usart1_rx_line = st_ff.d_in[PD_RXD]; // R02
  assign o_usart1_ext_clock_in = st_ff.d_in[PD_XCK];
  assign o_timer1_capture_in = st_ff.d_in[PD_CAP]; // R10
  assign o_timer1_count_in = st_ff.d_in[PD_T1]; // R10
  assign o_timer2_count_in = st_ff.d_in[PD_T2]; // R10
  assign o_sda_in = tw_lines.clean[1]; // R06
  assign o_scl_in = tw_lines.clean[0]; // R06
  assign o_ext_irq_line = {st_ff.e_in[7:4], st_ff.d_in[3:0]};
  assign o_usart0_rx_line = st_ff.e_in[PE_RXD];
  assign o_usart0_ext_clock_in = st_ff.e_in[PE_XCK];
  assign o_timer3_capture_in = st_ff.e_in[PE_CAP]; // R15
  assign o_timer3_count_in = st_ff.e_in[PE_T3]; // R15
  assign o_prog_serial_data_in = st_ff.e_in[PE_RXD]; // R16

  AST_PLAIN_PORT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R01
    ##1 (o_portd_oe[PD_T2] == $past(i_portd_dir[PD_T2])) && (o_porte_drive[PE_T3] == $past(i_porte_out[PE_T3])))
    else $error("unoverridden pin does not follow its port registers");
  AST_RX1_INPUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R02
    i_usart1_rx_enable |=> !o_portd_oe[PD_RXD])
    else $error("usart1 receive pin not forced to input");
  AST_RX1_PULLUP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R03
    i_usart1_rx_enable |=> o_portd_pullup[PD_RXD] == ($past(i_portd_out[PD_RXD]) && !$past(global_pullup_disable)))
    else $error("usart1 receive pull-up wrong");
  AST_SDA_OPEN_DRAIN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R04
    tw |=> !o_portd_drive[PD_SDA] && (o_portd_oe[PD_SDA] == $past(i_sda_drive_low)))
    else $error("SDA not open drain");
  AST_SCL_OPEN_DRAIN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R05
    tw |=> !o_portd_drive[PD_SCL] && (o_portd_oe[PD_SCL] == $past(i_scl_drive_low))
    && (o_portd_pullup[PD_SCL] == ($past(i_portd_out[PD_SCL]) && !$past(global_pullup_disable))))
    else $error("SCL not open drain");
  AST_TX1_DRIVE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R08
    i_usart1_tx_enable |=> o_portd_oe[PD_TXD] && !o_portd_pullup[PD_TXD]
    && (o_portd_drive[PD_TXD] == $past(i_usart1_tx_line)))
    else $error("usart1 transmit pin not driven");
  AST_IRQ_INPUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R09
    (i_ext_irq_enable[2] && i_ext_irq_enable[6]) |=> o_portd_in_en[PD_RXD] && o_porte_in_en[PE_T3])
    else $error("interrupt pin input not enabled");
  AST_USART1_EXT_CLOCK_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R10
    i_usart1_sync_select |=> o_portd_drive[PD_XCK] == $past(i_usart1_ext_clock))
    else $error("usart1 clock not driven");
  AST_RX0_INPUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R11
    (i_usart0_rx_enable && !prog) |=> !o_porte_oe[PE_RXD]
    && (o_porte_pullup[PE_RXD] == ($past(i_porte_out[PE_RXD]) && !$past(global_pullup_disable))))
    else $error("usart0 receive pin wrong");
  AST_TX0_DRIVE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R12
    (i_usart0_tx_enable && !prog) |=> o_porte_oe[PE_TXD] && !o_porte_pullup[PE_TXD]
    && (o_porte_drive[PE_TXD] == $past(i_usart0_tx_line)))
    else $error("usart0 transmit pin not driven");
  AST_TIMER3_COMPARE_A_OUT_VALUE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R13
    i_timer3_compare_en[0] |=> (o_porte_drive[PE_OCA] == $past(i_timer3_compare_out[0]))
    && (o_porte_oe[PE_OCA] == $past(i_porte_dir[PE_OCA])))
    else $error("timer3 compare A not on pin");
  AST_USART0_EXT_CLOCK_DIR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R14
    i_usart0_sync_select |=> (o_porte_drive[PE_XCK] == $past(i_usart0_ext_clock))
    && (o_porte_oe[PE_XCK] == $past(i_porte_dir[PE_XCK])))
    else $error("usart0 clock pin wrong");
  AST_T3_CAPTURE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R15
    st_ff.e_ie[PE_CAP] |=> o_timer3_capture_in == $past(st_ff.e_s2[PE_CAP]))
    else $error("timer3 capture input not routed");
  AST_PROG_PINS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // R16
    prog |=> o_porte_oe[PE_TXD] && !o_porte_oe[PE_RXD]
    && (o_porte_drive[PE_TXD] == $past(i_prog_serial_data_out)))
    else $error("programming pins wrong");
endmodule
`default_nettype wire

/* dv/pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
// pad side of the port: open-drain bus lines on BUS_MASK, other pins external driver or pull-up
module pad_model #(parameter logic [7:0] BUS_MASK = 8'h00) (
  input wire logic i_sys_clk,       // clock for the floating pattern
  input wire logic [7:0] i_oe,      // pin output enable
  input wire logic [7:0] i_drive,   // pin output value
  input wire logic [7:0] i_pullup,  // pin pull-up on
  input wire logic [7:0] i_ext_en,  // external driver on
  input wire logic [7:0] i_ext_val, // external driver value
  output logic [7:0] o_pad          // pad level
);
  logic flt_ff = 1'b0;
  always @(posedge i_sys_clk) flt_ff <= ~flt_ff;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // a bus line only ever gets pulled low; the external pull-up holds it high
      if (BUS_MASK[i]) o_pad[i] = ~((i_oe[i] & ~i_drive[i]) | (i_ext_en[i] & ~i_ext_val[i]));
      else if (i_oe[i]) o_pad[i] = i_drive[i];
      else if (i_ext_en[i]) o_pad[i] = i_ext_val[i];
      else if (i_pullup[i]) o_pad[i] = 1'b1;
      else o_pad[i] = flt_ff; // floating pin: never settle on a level the bench could trust
    end
  end
endmodule
`default_nettype wire

/* dv/portd_porte_alt_function_override_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module portd_porte_alt_function_override_tb;
  import pin_alt_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] d_out = 8'h00, d_dir = 8'h00, e_out = 8'h00, e_dir = 8'h00, irq = 8'h00;
  logic [7:0] d_xe = 8'h00, d_xv = 8'h00, e_xe = 8'h00, e_xv = 8'h00;
  logic global_pullup_disable = 1'b0, idis = 1'b0, u1rx = 1'b0, u1tx = 1'b0, u1txd = 1'b0, u1sy = 1'b0, u1ck = 1'b0;
  logic u0rx = 1'b0, u0tx = 1'b0, u0txd = 1'b0, u0sy = 1'b0, u0ck = 1'b0, tw = 1'b0;
  logic sdal = 1'b0, scll = 1'b0, prog = 1'b0, progd = 1'b0;
  logic [2:0] t3en = 3'h0, t3o = 3'h0;
  logic [7:0] d_pu, d_oe, d_dr, d_ie, d_in, e_pu, e_oe, e_dr, e_ie, e_in, irql, d_pad, e_pad;
  logic u1rxl, u1cki, t1cap, t1cnt, t2cnt, sda, scl, u0rxl, u0cki, t3cap, t3cnt, pdin;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  pin_alt_override dut_u (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_portd_out(d_out), .i_portd_dir(d_dir),
    .i_portd_pin(d_pad), .i_porte_out(e_out), .i_porte_dir(e_dir), .i_porte_pin(e_pad),
    .i_global_pullup_disable(global_pullup_disable), .i_input_disable(idis), .i_usart1_rx_enable(u1rx),
    .i_usart1_tx_enable(u1tx), .i_usart1_tx_line(u1txd), .i_usart1_sync_select(u1sy),
    .i_usart1_ext_clock(u1ck), .i_usart0_rx_enable(u0rx), .i_usart0_tx_enable(u0tx),
    .i_usart0_tx_line(u0txd), .i_usart0_sync_select(u0sy), .i_usart0_ext_clock(u0ck),
    .i_two_wire_enable(tw), .i_sda_drive_low(sdal), .i_scl_drive_low(scll),
    .i_ext_irq_enable(irq), .i_timer3_compare_en(t3en), .i_timer3_compare_out(t3o),
    .i_prog_serial_mode(prog), .i_prog_serial_data_out(progd),
    .o_portd_pullup(d_pu), .o_portd_oe(d_oe), .o_portd_drive(d_dr), .o_portd_in_en(d_ie),
    .o_portd_in(d_in), .o_porte_pullup(e_pu), .o_porte_oe(e_oe), .o_porte_drive(e_dr),
    .o_porte_in_en(e_ie), .o_porte_in(e_in), .o_usart1_rx_line(u1rxl),
    .o_usart1_ext_clock_in(u1cki), .o_timer1_capture_in(t1cap), .o_timer1_count_in(t1cnt),
    .o_timer2_count_in(t2cnt), .o_sda_in(sda), .o_scl_in(scl), .o_ext_irq_line(irql),
    .o_usart0_rx_line(u0rxl), .o_usart0_ext_clock_in(u0cki), .o_timer3_capture_in(t3cap),
    .o_timer3_count_in(t3cnt), .o_prog_serial_data_in(pdin)
  );

  pad_model #(.BUS_MASK(8'h03)) pad_d_u (.i_sys_clk(i_sys_clk), .i_oe(d_oe), .i_drive(d_dr),
    .i_pullup(d_pu), .i_ext_en(d_xe), .i_ext_val(d_xv), .o_pad(d_pad));
  pad_model #(.BUS_MASK(8'h00)) pad_e_u (.i_sys_clk(i_sys_clk), .i_oe(e_oe), .i_drive(e_dr),
    .i_pullup(e_pu), .i_ext_en(e_xe), .i_ext_val(e_xv), .o_pad(e_pad));

  always #2.5 i_sys_clk = ~i_sys_clk;

  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // whole run is about 120 cycles; this ceiling only catches a hang
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    step(16);
    chk(d_oe | e_oe | d_pu | e_dr, 8'h00);
    chk({6'h00, sda, scl}, 8'h03);
    i_rstn = 1'b1;
    step(3);
    // plain port: register values pass through, pull-up from out and not dir
    d_dir = 8'hF0; d_out = 8'hAA; e_dir = 8'h0F; e_out = 8'h55; d_xe = 8'h0C; d_xv = 8'h04;
    step(1);
    chk(d_oe, 8'hF0);
    chk(d_dr, 8'hAA);
    chk(d_pu, 8'h0A);
    chk(e_pu, 8'h50);
    chk(d_ie, 8'hFF);
    global_pullup_disable = 1'b1;
    step(1);
    chk(d_pu | e_pu, 8'h00);
    global_pullup_disable = 1'b0;
    step(4);
    chk(d_in, 8'hA7);
    chk({4'h0, t2cnt, t1cnt, t1cap, u1cki}, 8'h09);
    chk({7'h00, u1rxl}, 8'h01);
    // usart1 transmitter owns D3
    d_dir = 8'h00; d_out = 8'h08; u1tx = 1'b1; u1txd = 1'b1;
    step(1);
    chk(d_oe, 8'h08);
    chk(d_dr, 8'h08);
    chk(d_pu, 8'h00);
    u1txd = 1'b0;
    step(1);
    chk(d_dr, 8'h00);
    u1tx = 1'b0;
    // usart1 receiver forces D2 in, pull-up still from the port bit
    d_dir = 8'h04; d_out = 8'h04; u1rx = 1'b1;
    step(1);
    chk(d_oe, 8'h00);
    chk(d_pu, 8'h04);
    global_pullup_disable = 1'b1;
    step(1);
    chk(d_pu, 8'h00);
    global_pullup_disable = 1'b0; u1rx = 1'b0;
    step(1);
    chk(d_oe, 8'h04);
    // interrupt enables keep inputs alive while inputs are disabled
    d_dir = 8'h00; d_out = 8'h00; idis = 1'b1; irq = 8'h65; e_dir = 8'h00; e_xe = 8'hFF; e_xv = 8'h20;
    step(1);
    chk(d_ie, 8'h05);
    chk(e_ie, 8'h60);
    step(4);
    chk(irql, 8'h25);
    chk(e_in, 8'h20);
    idis = 1'b0; irq = 8'h00;
    // usart1 sync clock replaces D5 value only
    d_dir = 8'h20; u1sy = 1'b1; u1ck = 1'b1;
    step(1);
    chk(d_dr, 8'h20);
    chk(d_oe, 8'h20);
    u1sy = 1'b0;
    step(1);
    chk(d_dr, 8'h00);
    // usart0 receiver and transmitter on E0 and E1
    d_dir = 8'h00; e_dir = 8'h01; e_out = 8'h03; u0rx = 1'b1; u0tx = 1'b1; u0txd = 1'b0;
    e_xe = 8'hC1; e_xv = 8'hC1;
    step(1);
    chk(e_oe, 8'h02);
    chk(e_dr, 8'h01);
    chk(e_pu, 8'h01);
    global_pullup_disable = 1'b1;
    step(1);
    chk(e_pu, 8'h00);
    global_pullup_disable = 1'b0;
    step(3);
    chk({5'h00, u0rxl, t3cap, t3cnt}, 8'h07);
    e_xv = 8'h40;
    step(4);
    chk({5'h00, u0rxl, t3cap, t3cnt}, 8'h01);
    u0rx = 1'b0; u0tx = 1'b0;
    // timer3 compares; software has set the directions itself
    e_dir = 8'h38; e_out = 8'h00; e_xe = 8'h00; t3en = 3'b111; t3o = 3'b101;
    step(1);
    chk(e_dr, 8'h28);
    chk(e_oe, 8'h38);
    t3en = 3'b011; t3o = 3'b110;
    step(1);
    chk(e_dr, 8'h10);
    t3en = 3'b000;
    // usart0 sync clock: value overridden, direction bit picks in or out
    e_dir = 8'h00; u0sy = 1'b1; u0ck = 1'b1; e_xe = 8'h04; e_xv = 8'h04;
    step(1);
    chk(e_dr, 8'h04);
    chk(e_oe, 8'h00);
    step(3);
    chk({7'h00, u0cki}, 8'h01);
    e_dir = 8'h04; e_xe = 8'h00;
    step(1);
    chk(e_oe, 8'h04);
    u0sy = 1'b0; e_dir = 8'h00;
    // serial programming on E1 out and E0 in
    prog = 1'b1; progd = 1'b1; e_out = 8'h02; e_xe = 8'h01; e_xv = 8'h01;
    step(1);
    chk(e_oe, 8'h02);
    chk(e_dr, 8'h02);
    chk(e_pu, 8'h00);
    step(3);
    chk({7'h00, pdin}, 8'h01);
    prog = 1'b0; e_xe = 8'h00;
    // two-wire: open drain on D1/D0 with gated pull-ups
    d_dir = 8'h03; d_out = 8'h03; tw = 1'b1; sdal = 1'b1; scll = 1'b0; d_xe = 8'h00;
    step(1);
    chk(d_oe, 8'h02);
    chk(d_dr, 8'h00);
    chk(d_pu, 8'h03);
    sdal = 1'b0;
    step(20);
    chk({6'h00, sda, scl}, 8'h03);
    // a 9-cycle dip is a spike and must vanish
    d_xe = 8'h02; d_xv = 8'h00;
    step(9);
    d_xe = 8'h00;
    repeat (20) begin
      step(1);
      chk({7'h00, sda}, 8'h01);
    end
    d_xe = 8'h01;
    step(16);
    chk({6'h00, sda, scl}, 8'h02);
    final_report();
  end
endmodule
`default_nettype wire
